// ---- verilog/sys_write_protect_usb_detect.sv ----
// Write-protect lock, protected registers and USB insertion detect behind AXI4-Lite
`timescale 1ns/1ps

module sys_write_protect_usb_detect #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              usb_plus_line,
  input  wire logic              usb_minus_line,
  output logic [31:0]            watchdog_control,
  output logic [31:0]            watchdog_alt_control,
  output logic [31:0]            peripheral_reset_control,
  output logic [31:0]            fuse_control,
  output logic [31:0]            fuse_trigger,
  output logic [31:0]            fuse_flash_permission,
  output logic                   protection_disabled,
  output logic                   usb_insert_event,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: write channel capture
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_full_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              w_full_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              do_write;
  logic [7:0]        wr_off;
  logic              wr_hit;

  assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_full_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  // Address and data may arrive in either order
  assign do_write      = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_off        = 8'(aw_addr_reg);

  // Address holding register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end
  end

  // Data holding register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end
  end

  // Write response, held until the master takes it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= sys_protect_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? sys_protect_pkg::RESP_OKAY : sys_protect_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Byte-lane merge of held write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key sequence
  sys_protect_pkg::key_state_t key_state_reg;
  logic                        unlocked_reg;
  logic                        key_write;
  logic [7:0]                  key_byte;
  logic                        unlock_pulse;

  // Key byte only counts when its lane is enabled
  assign key_write    = do_write && (wr_off == sys_protect_pkg::OFF_WPCTL) && w_strb_reg[0];
  assign key_byte     = w_data_reg[7:0];
  assign unlock_pulse = key_write && !unlocked_reg &&
                        (key_state_reg == sys_protect_pkg::KEY_WAIT3) &&
                        (key_byte == sys_protect_pkg::KEY_THIRD);
  assign protection_disabled = unlocked_reg;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      key_state_reg <= sys_protect_pkg::KEY_WAIT1;
    end else if (key_write) begin
      unique case (key_state_reg)
        sys_protect_pkg::KEY_WAIT1: begin
          key_state_reg <= (key_byte == sys_protect_pkg::KEY_FIRST) ?
                           sys_protect_pkg::KEY_WAIT2 : sys_protect_pkg::KEY_WAIT1;
        end
        sys_protect_pkg::KEY_WAIT2: begin
          key_state_reg <= (key_byte == sys_protect_pkg::KEY_SECOND) ?
                           sys_protect_pkg::KEY_WAIT3 : sys_protect_pkg::KEY_WAIT1;
        end
        sys_protect_pkg::KEY_WAIT3: begin
          key_state_reg <= sys_protect_pkg::KEY_WAIT1;
        end
        default: begin
          key_state_reg <= sys_protect_pkg::KEY_WAIT1;
        end
      endcase
    end
  end

  // status set only by full key
  // Any key-field write while open closes the lock again
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      unlocked_reg <= 1'b0;
    end else if (unlock_pulse) begin
      unlocked_reg <= 1'b1;
    end else if (key_write) begin
      unlocked_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protected registers
  localparam logic [7:0] PROT_OFF [sys_protect_pkg::PROT_COUNT] = '{
    sys_protect_pkg::OFF_WATCHDOG_CONTROL, sys_protect_pkg::OFF_WDT_ALT,
    sys_protect_pkg::OFF_PRST, sys_protect_pkg::OFF_FUSE_CTL,
    sys_protect_pkg::OFF_FUSE_TRG, sys_protect_pkg::OFF_FUSE_PERM
  };

  logic [31:0]                         prot_reg [sys_protect_pkg::PROT_COUNT];
  logic [sys_protect_pkg::PROT_COUNT-1:0] prot_hit;
  logic                                blocked_pulse;

  genvar gi;
  generate
    for (gi = 0; gi < sys_protect_pkg::PROT_COUNT; gi++) begin : g_prot
      assign prot_hit[gi] = (wr_off == PROT_OFF[gi]);
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          prot_reg[gi] <= sys_protect_pkg::RST_PROT;
        end else if (do_write && prot_hit[gi] && unlocked_reg) begin
          prot_reg[gi] <= merge(prot_reg[gi], w_data_reg, w_strb_reg);
        end
      end
    end
  endgenerate

  assign watchdog_control         = prot_reg[0];
  assign watchdog_alt_control     = prot_reg[1];
  assign peripheral_reset_control = prot_reg[2];
  assign fuse_control             = prot_reg[3];
  assign fuse_trigger             = prot_reg[4];
  assign fuse_flash_permission    = prot_reg[5];
  // A refused write still answers OKAY; only the status bit tells software
  assign blocked_pulse            = do_write && (|prot_hit) && !unlocked_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and interrupt registers
  logic [15:0]                      removal_cycles_reg;
  logic [sys_protect_pkg::IRQ_BITS-1:0] irq_stat_reg;
  logic [sys_protect_pkg::IRQ_BITS-1:0] irq_mask_reg;
  logic [sys_protect_pkg::IRQ_BITS-1:0] irq_set;
  logic [sys_protect_pkg::IRQ_BITS-1:0] irq_clr;
  logic                             removal_pulse;

  // Only the low half of word 1 is writable
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      removal_cycles_reg <= sys_protect_pkg::RST_REMOVAL;
    end else if (do_write && wr_off == sys_protect_pkg::OFF_CTRL1) begin
      removal_cycles_reg <= 16'(merge({16'h0000, removal_cycles_reg}, w_data_reg, w_strb_reg));
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_mask_reg <= '0;
    end else if (do_write && wr_off == sys_protect_pkg::OFF_IRQ_MASK && w_strb_reg[0]) begin
      irq_mask_reg <= w_data_reg[sys_protect_pkg::IRQ_BITS-1:0];
    end
  end

  assign irq_set[sys_protect_pkg::IRQ_INSERT]  = usb_insert_event;
  assign irq_set[sys_protect_pkg::IRQ_REMOVAL] = removal_pulse;
  assign irq_set[sys_protect_pkg::IRQ_UNLOCK]  = unlock_pulse;
  assign irq_set[sys_protect_pkg::IRQ_BLOCKED] = blocked_pulse;
  assign irq_clr = (do_write && wr_off == sys_protect_pkg::OFF_IRQ_STAT && w_strb_reg[0]) ?
                   w_data_reg[sys_protect_pkg::IRQ_BITS-1:0] : '0;

  // Sticky status, a new event beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  assign wr_hit = (|prot_hit) || wr_off == sys_protect_pkg::OFF_WPCTL ||
                  wr_off == sys_protect_pkg::OFF_ROMSTAT || wr_off == sys_protect_pkg::OFF_CTRL0 ||
                  wr_off == sys_protect_pkg::OFF_CTRL1 || wr_off == sys_protect_pkg::OFF_IRQ_STAT ||
                  wr_off == sys_protect_pkg::OFF_IRQ_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // USB removal qualification and insertion detect
  sys_protect_pkg::line_state_t line_state_reg;
  logic [15:0]                  high_count_reg;
  logic                         both_high;
  logic                         both_low;

  assign both_high = usb_plus_line & usb_minus_line;
  assign both_low  = ~usb_plus_line & ~usb_minus_line;

  // uninterrupted high count
  // Counts block clock cycles; saturates so a long idle cannot wrap
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      high_count_reg <= 16'h0000;
    end else if (!both_high || line_state_reg == sys_protect_pkg::LINE_REMOVED) begin
      high_count_reg <= 16'h0000;
    end else if (high_count_reg != 16'hFFFF) begin
      high_count_reg <= high_count_reg + 16'h0001;
    end
  end

  assign removal_pulse = (line_state_reg == sys_protect_pkg::LINE_QUALIFY) && both_high &&
                         (high_count_reg >= removal_cycles_reg);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      line_state_reg   <= sys_protect_pkg::LINE_QUALIFY;
      usb_insert_event <= 1'b0;
    end else begin
      usb_insert_event <= 1'b0;
      unique case (line_state_reg)
        sys_protect_pkg::LINE_QUALIFY: begin
          if (removal_pulse) begin
            line_state_reg <= sys_protect_pkg::LINE_REMOVED;
          end
        end
        sys_protect_pkg::LINE_REMOVED: begin
          if (both_low) begin
            line_state_reg   <= sys_protect_pkg::LINE_QUALIFY;
            usb_insert_event <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: read channel
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_value;
  logic        rd_hit;
  logic [7:0]  rd_off;

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_off        = 8'(s_axi_araddr);

  // Read mux; key byte never reads back
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    for (int i = 0; i < sys_protect_pkg::PROT_COUNT; i++) begin
      if (rd_off == PROT_OFF[i]) begin
        rd_value = prot_reg[i];
      end
    end
    if (rd_off == sys_protect_pkg::OFF_WPCTL) begin
      rd_value = {31'h0000_0000, unlocked_reg};
    end else if (rd_off == sys_protect_pkg::OFF_ROMSTAT) begin
      rd_value = sys_protect_pkg::RST_ROMSTAT;
    end else if (rd_off == sys_protect_pkg::OFF_CTRL0) begin
      rd_value = sys_protect_pkg::RST_CTRL0;
    end else if (rd_off == sys_protect_pkg::OFF_CTRL1) begin
      rd_value = {sys_protect_pkg::CTRL1_UPPER, removal_cycles_reg};
    end else if (rd_off == sys_protect_pkg::OFF_IRQ_STAT) begin
      rd_value = {28'h000_0000, irq_stat_reg};
    end else if (rd_off == sys_protect_pkg::OFF_IRQ_MASK) begin
      rd_value = {28'h000_0000, irq_mask_reg};
    end else if (!(|{rd_off == PROT_OFF[0], rd_off == PROT_OFF[1], rd_off == PROT_OFF[2],
                    rd_off == PROT_OFF[3], rd_off == PROT_OFF[4], rd_off == PROT_OFF[5]})) begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= sys_protect_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= rd_hit ? sys_protect_pkg::RESP_OKAY : sys_protect_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : sys_write_protect_usb_detect

// ---- verilog/sys_protect_pkg.sv ----
// Package with offsets, reset values and encodings of the write-protect and USB-detect bank
package sys_protect_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_WATCHDOG_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_WDT_ALT   = 8'h04;
  localparam logic [7:0] OFF_PRST      = 8'h08;
  localparam logic [7:0] OFF_FUSE_CTL  = 8'h0C;
  localparam logic [7:0] OFF_FUSE_TRG  = 8'h10;
  localparam logic [7:0] OFF_FUSE_PERM = 8'h14;
  localparam logic [7:0] OFF_WPCTL     = 8'h40;
  localparam logic [7:0] OFF_ROMSTAT   = 8'h44;
  localparam logic [7:0] OFF_CTRL0     = 8'h48;
  localparam logic [7:0] OFF_CTRL1     = 8'h4C;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h50;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h54;
  // Reset values
  localparam logic [31:0] RST_PROT     = 32'h0000_0000;
  localparam logic [31:0] RST_ROMSTAT  = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL0    = 32'h3F3F_FFC0;
  localparam logic [31:0] RST_CTRL1    = 32'h0004_0004;
  localparam logic [15:0] RST_REMOVAL  = 16'h0004;
  localparam logic [15:0] CTRL1_UPPER  = 16'h0004;
  // Unlock key bytes, in order
  localparam logic [7:0] KEY_FIRST     = 8'h59;
  localparam logic [7:0] KEY_SECOND    = 8'h16;
  localparam logic [7:0] KEY_THIRD     = 8'h88;
  // Interrupt status bit positions
  localparam int IRQ_INSERT  = 0;
  localparam int IRQ_REMOVAL = 1;
  localparam int IRQ_UNLOCK  = 2;
  localparam int IRQ_BLOCKED = 3;
  localparam int IRQ_BITS    = 4;
  localparam int PROT_COUNT  = 6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KEY_WAIT1 = 2'b00,
    KEY_WAIT2 = 2'b01,
    KEY_WAIT3 = 2'b10
  } key_state_t;

  typedef enum logic {
    LINE_QUALIFY = 1'b0,
    LINE_REMOVED = 1'b1
  } line_state_t;
endpackage : sys_protect_pkg

// ---- verif/sys_protect_asserts.sv ----
// Checker of bus answers, lock behaviour and insertion detect at the block ports
`timescale 1ns/1ps
module sys_protect_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              usb_plus_line,
  input wire logic              usb_minus_line,
  input wire logic [31:0]       watchdog_control,
  input wire logic [31:0]       peripheral_reset_control,
  input wire logic [31:0]       fuse_flash_permission,
  input wire logic              protection_disabled,
  input wire logic              usb_insert_event
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Both write channels taken at one edge
  wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic wp_take = wr_take && (s_axi_awaddr == ADDR_W'(sys_protect_pkg::OFF_WPCTL));
  logic key3_q;
  logic wp_q;
  logic hi_seen;
  // Remember key writes; unlock may lag the write by one cycle
  always_ff @(posedge mclk) begin
    key3_q <= reset_n && wp_take && (s_axi_wdata[7:0] == sys_protect_pkg::KEY_THIRD);
    wp_q   <= reset_n && wp_take;
  end
  // Lines seen high since the last insertion
  always_ff @(posedge mclk) begin
    if (!reset_n || usb_insert_event) hi_seen <= 1'b0;
    else if (usb_plus_line && usb_minus_line) hi_seen <= 1'b1;
  end
  sequence wr_taken;
    wr_take && s_axi_bready;
  endsequence
  // Both channels land in holding registers first, so the answer comes one cycle later
  sequence resp_pulse;
    !s_axi_bvalid ##1 s_axi_bvalid ##1 !s_axi_bvalid;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////////////////
  a_wr_answer: assert property (wr_taken |=> resp_pulse)
    else $error("write response not two cycles after the write");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after the address");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");
  a_unlock_key: assert property ($rose(protection_disabled) |-> key3_q || $past(key3_q))
    else $error("lock opened without the last key byte");
  a_relock_write: assert property ($fell(protection_disabled) |-> wp_q || $past(wp_q))
    else $error("lock closed without a key field write");
  a_locked_hold: assert property (!protection_disabled |=> $stable(watchdog_control)
    && $stable(peripheral_reset_control) && $stable(fuse_flash_permission))
    else $error("protected register changed while locked");
  a_insert_pulse: assert property (usb_insert_event |=> !usb_insert_event)
    else $error("insertion event longer than one cycle");
  a_insert_low: assert property (usb_insert_event |->
    !$past(usb_plus_line) && !$past(usb_minus_line))
    else $error("insertion event without both lines low");
  a_insert_removed: assert property (usb_insert_event |-> hi_seen)
    else $error("insertion event without a removal run");
endmodule : sys_protect_asserts

// ---- verif/testbench.sv ----
// Self-checking bench for the write-protect and USB-detect register bank
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0, reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        usb_plus_line = 1'b0, usb_minus_line = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] watchdog_control, watchdog_alt_control, peripheral_reset_control;
  logic [31:0] fuse_control, fuse_trigger, fuse_flash_permission;
  logic        protection_disabled, usb_insert_event, irq;
  int          miscompares = 0, checked = 0, inserts = 0;
  logic [31:0] prot [6];
  logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};

  sys_write_protect_usb_detect dut (.*);
  assign prot = '{watchdog_control, watchdog_alt_control, peripheral_reset_control,
                  fuse_control, fuse_trigger, fuse_flash_permission};
  // Clock of 25 ns
  always #12.5 mclk = ~mclk;
  // Count insertion pulses, sampled once per cycle
  always @(posedge mclk) if (usb_insert_event === 1'b1) inserts++;
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = sys_protect_pkg::RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!s_axi_bvalid && n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check("bvalid", 32'(s_axi_bvalid), 32'h1);
    check("bresp", 32'(s_axi_bresp), 32'(er));
    // One idle edge so no strobe is driven twice in a time step
    @(posedge mclk);
  endtask : wr

  // Read: data is only compared when an OKAY answer is expected
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = sys_protect_pkg::RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!s_axi_rvalid && n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check("rvalid", 32'(s_axi_rvalid), 32'h1);
    check("rresp", 32'(s_axi_rresp), 32'(er));
    if (er == sys_protect_pkg::RESP_OKAY) check("rdata", s_axi_rdata, e);
    @(posedge mclk);
  endtask : rd

  task automatic lines(input logic p, input logic m, input int n);
    usb_plus_line <= p;
    usb_minus_line <= m;
    repeat (n) @(posedge mclk);
  endtask : lines

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    wr(8'h48, 32'h0);
    rd(8'h48, 32'h3F3F_FFC0);
    wr(8'h4C, 32'hFFFF_1234);
    rd(8'h4C, 32'h0004_1234);
    wr(8'h60, 32'h1, sys_protect_pkg::RESP_SLVERR);
    rd(8'h60, 32'h0, sys_protect_pkg::RESP_SLVERR);
    $display("test map done");
    wr(8'h00, 32'hA5A5_0001);
    check("watchdog_control", watchdog_control, 32'h0);
    wr(8'h40, 32'h59);
    wr(8'h40, 32'h16);
    wr(8'h40, 32'h00);
    wr(8'h40, 32'h59);
    wr(8'h40, 32'h88);
    check("protection_disabled", 32'(protection_disabled), 32'h0);
    wr(8'h40, 32'h59);
    wr(8'h40, 32'h16);
    wr(8'h40, 32'h88);
    check("protection_disabled", 32'(protection_disabled), 32'h1);
    rd(8'h40, 32'h1);
    $display("test key done");
    for (int i = 0; i < 6; i++) wr(offs[i], 32'h1000_0000 + i);
    for (int i = 0; i < 6; i++) check("protected", prot[i], 32'h1000_0000 + i);
    // Status holds unlock and blocked-write events
    rd(8'h50, 32'h0000_000C);
    wr(8'h54, 32'h8);
    check("irq", 32'(irq), 32'h1);
    wr(8'h50, 32'h8);
    check("irq", 32'(irq), 32'h0);
    rd(8'h50, 32'h0000_0004);
    wr(8'h40, 32'h00);
    check("protection_disabled", 32'(protection_disabled), 32'h0);
    wr(8'h00, 32'h0000_FFFF);
    check("watchdog_control", watchdog_control, 32'h1000_0000);
    $display("test unlocked done");
    wr(8'h50, 32'hF);
    wr(8'h54, 32'h1);
    wr(8'h4C, 32'h2);
    // Exactly the count of high cycles is one short of removal
    lines(1'b1, 1'b1, 2);
    lines(1'b0, 1'b1, 1);
    lines(1'b0, 1'b0, 4);
    check("inserts", 32'(inserts), 32'h0);
    rd(8'h50, 32'h0);
    lines(1'b1, 1'b1, 3);
    lines(1'b0, 1'b0, 4);
    check("inserts", 32'(inserts), 32'h1);
    check("irq", 32'(irq), 32'h1);
    rd(8'h50, 32'h0000_0003);
    wr(8'h50, 32'h1);
    check("irq", 32'(irq), 32'h0);
    $display("test usb done");
    give_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule : testbench

bind sys_write_protect_usb_detect sys_protect_asserts #(.ADDR_W(ADDR_W)) chk (.*);
